// >>> rtl/pdg_pkg.sv
package pdg_pkg;

  // ********************************
  // Clock and timing
  // ********************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int FSTEP_HZ = 5000;
  localparam int DT_STEP_NS = 400;
  localparam int DEB_US = 1000;
  localparam int DEB_CYC = DEB_US * 1000 / CLK_NS;
  localparam int DEB_W = 15;
  localparam int CW = 12;
  localparam logic [CW-1:0] PERIOD_BASE = CW'(CLK_HZ / FSTEP_HZ);
  localparam logic [CW-1:0] DT_STEP_CYC = CW'(DT_STEP_NS / CLK_NS);

  // ********************************
  // Switch bank and duty input
  // ********************************
  localparam int SW_W = 6;
  localparam int SEL_W = 3;
  localparam int FSEL_LSB = 0;
  localparam int DSEL_LSB = 3;
  localparam logic [SW_W-1:0] SW_ALL_ON = 6'h3f;
  localparam int POT_W = 8;
  localparam logic [POT_W-1:0] POT_MAX = 8'hfa;

  // ********************************
  // Buttons
  // ********************************
  localparam int NBTN = 3;
  localparam int BTN_START = 0;
  localparam int BTN_SLEEP = 1;
  localparam int BTN_RESET = 2;

  // ********************************
  // APB register map
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DUTY = 8'h08;
  localparam int CTRL_START = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int ST_RUN = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_EXT = 2;
  localparam int ST_CFG_LSB = 8;
  localparam int ST_PER_LSB = 16;

  typedef struct packed {
    logic run;
    logic sleep;
    logic ext;
    logic [SW_W-1:0] cfg;
    logic [CW-1:0] period;
    logic [CW-1:0] dt;
    logic [CW-1:0] on;
    logic [CW-1:0] cnt;
    logic [NBTN-1:0] btn;
    logic [NBTN-1:0][DEB_W-1:0] deb;
    logic hi;
    logic lo;
    logic pready;
    logic [31:0] prdata;
  } pdg_state_t;

endpackage : pdg_pkg

// >>> rtl/pdg_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pdg_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ********************************
  // Two-stage synchroniser
  // ********************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pdg_sync
`default_nettype wire

// >>> rtl/pdg_top.sv
`timescale 1ns/1ns
`default_nettype none
module pdg_top import pdg_pkg::*; #(
  parameter int DEB_CYCLES = DEB_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [SW_W-1:0] config_switch_bank,
  input wire logic [POT_W-1:0] duty_potentiometer,
  input wire logic [NBTN-1:0] buttons_n,
  input wire logic ext_high_in,
  input wire logic ext_low_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic high_side_drive_in,
  output logic low_side_drive_in
);

  // ********************************
  // Decoding helpers
  // ********************************
  function automatic logic [CW-1:0] period_of(input logic [SW_W-1:0] c);
    logic [CW-1:0] div;
    div = CW'(c[FSEL_LSB +: SEL_W]) + CW'(1);
    return PERIOD_BASE / div;
  endfunction : period_of

  function automatic logic [CW-1:0] dt_of(input logic [SW_W-1:0] c);
    logic [2*CW-1:0] p;
    p = (2*CW)'(c[DSEL_LSB +: SEL_W]) * (2*CW)'(DT_STEP_CYC);
    return p[CW-1:0];
  endfunction : dt_of

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [SW_W-1:0] sw_s;
  logic [POT_W-1:0] pot_s;
  logic [NBTN-1:0] btn_s;
  logic [1:0] ext_s;

  // Buttons inverted first, so a reset sync reads as released
  pdg_sync #(.W(SW_W+POT_W+NBTN+2)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .d({config_switch_bank, duty_potentiometer, ~buttons_n,
        ext_high_in, ext_low_in}),
    .q({sw_s, pot_s, btn_s, ext_s})
  );

  // ********************************
  // State
  // ********************************
  pdg_state_t st;
  pdg_state_t next_st;
  logic [NBTN-1:0] press;
  logic apb_start;
  logic apb_sleep;
  logic start_evt;
  logic sleep_evt;
  logic [POT_W-1:0] pot_c;
  logic [2*CW-1:0] on_prod;
  logic [CW:0] lo_edge;

  always_comb begin
    next_st = st;
    press = '0;
    apb_start = 1'b0;
    apb_sleep = 1'b0;
    // Debounce: a level must hold DEB_CYCLES before it counts
    for (int i = 0; i < NBTN; i++) begin
      if (btn_s[i] != st.btn[i]) begin
        if (st.deb[i] == DEB_W'(DEB_CYCLES - 1)) begin
          next_st.btn[i] = btn_s[i];
          next_st.deb[i] = '0;
          press[i] = btn_s[i];
        end else begin
          next_st.deb[i] = st.deb[i] + DEB_W'(1);
        end
      end else begin
        next_st.deb[i] = '0;
      end
    end
    // APB slave, one wait state
    next_st.pready = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      if (pwrite) begin
        if (paddr == REG_CTRL) begin
          apb_start = pwdata[CTRL_START];
          apb_sleep = pwdata[CTRL_SLEEP];
        end
      end else begin
        case (paddr)
          REG_STATUS: begin
            next_st.prdata[ST_RUN] = st.run;
            next_st.prdata[ST_SLEEP] = st.sleep;
            next_st.prdata[ST_EXT] = st.ext;
            next_st.prdata[ST_CFG_LSB +: SW_W] = st.cfg;
            next_st.prdata[ST_PER_LSB +: CW] = st.period;
          end
          REG_DUTY: begin
            next_st.prdata[CW-1:0] = st.on;
            next_st.prdata[ST_PER_LSB +: CW] = st.dt;
          end
          default: next_st.prdata = '0;
        endcase
      end
    end
    start_evt = press[BTN_START] | apb_start;
    sleep_evt = press[BTN_SLEEP] | apb_sleep;
    // Duty scales with the period, so it is frequency independent
    pot_c = (pot_s > POT_MAX) ? POT_MAX : pot_s;
    on_prod = (2*CW)'(st.period) * (2*CW)'(pot_c);
    lo_edge = {1'b0, st.on} + {1'b0, st.dt};
    if (press[BTN_RESET]) begin
      next_st.run = 1'b0;
      next_st.sleep = 1'b0;
      next_st.cnt = '0;
    end else if (sleep_evt) begin
      next_st.sleep = !st.sleep;
      next_st.run = 1'b0;
    end else if (start_evt && !st.sleep) begin
      next_st.run = !st.run;
      if (!st.run) begin
        next_st.cfg = sw_s;
        next_st.ext = (sw_s == SW_ALL_ON);
        next_st.period = period_of(sw_s);
        next_st.dt = dt_of(sw_s);
        next_st.cnt = '0;
        next_st.on = '0;
      end
    end else if (st.run) begin
      if (st.cnt == st.period - CW'(1)) begin
        next_st.cnt = '0;
        next_st.on = on_prod[POT_W +: CW];
      end else begin
        next_st.cnt = st.cnt + CW'(1);
      end
    end
    // Generated leading edges delayed by dead-time, trailing edges untouched; external inputs get no dead-time but pass three cycles late
    if (st.run && st.ext) begin
      next_st.hi = ext_s[1] && !ext_s[0];
      next_st.lo = ext_s[0] && !ext_s[1];
    end else begin
      next_st.hi = st.run && st.cnt < st.on && st.cnt >= st.dt;
      next_st.lo = st.run && {1'b0, st.cnt} >= lo_edge;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign high_side_drive_in = st.hi;
  assign low_side_drive_in = st.lo;
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = 1'b0;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_start;
    $rose(st.run);
  endsequence

  sequence s_gen_rise;
    $rose(st.hi) && !$past(st.ext);
  endsequence

  property p_no_overlap;
    !(high_side_drive_in && low_side_drive_in);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both drive outputs high");

  property p_stop_low;
    !st.run |=> !high_side_drive_in && !low_side_drive_in;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("output active while stopped");

  property p_cfg_latch;
    s_start |-> st.cfg == $past(sw_s) && st.period == period_of(st.cfg);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch)
    else $error("config not latched at start");

  property p_cfg_hold;
    st.run && $past(st.run) |-> $stable(st.cfg) && $stable(st.dt);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed while running");

  property p_dead_edge;
    s_gen_rise |-> $past(st.cnt) == st.dt;
  endproperty
  a_dead_edge: assert property (p_dead_edge)
    else $error("high edge not delayed by dead-time");

  property p_dt_step;
    st.run |-> st.dt == CW'(st.cfg[DSEL_LSB +: SEL_W]) * DT_STEP_CYC;
  endproperty
  a_dt_step: assert property (p_dt_step)
    else $error("dead-time count wrong");

  property p_period_wrap;
    st.run && st.cnt == st.period - CW'(1) && !start_evt && !sleep_evt
      && !press[BTN_RESET] |=> st.cnt == '0;
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("counter failed to wrap at period");

  property p_duty_cap;
    st.on < st.period || st.period == '0;
  endproperty
  a_duty_cap: assert property (p_duty_cap)
    else $error("on time reaches full period");

  property p_start_toggle;
    start_evt && !st.sleep && !sleep_evt && !press[BTN_RESET]
      |=> st.run != $past(st.run);
  endproperty
  a_start_toggle: assert property (p_start_toggle)
    else $error("start press did not toggle");

  property p_sleep_toggle;
    sleep_evt && !press[BTN_RESET] |=> st.sleep != $past(st.sleep) && !st.run;
  endproperty
  a_sleep_toggle: assert property (p_sleep_toggle)
    else $error("sleep press did not toggle");

  property p_ext_pass;
    st.run && st.ext |=> high_side_drive_in == ($past(ext_s[1])
      && !$past(ext_s[0]));
  endproperty
  a_ext_pass: assert property (p_ext_pass)
    else $error("external high not passed through");

endmodule : pdg_top
`default_nettype wire

// >>> tb/pdg_gate_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Gate driver inputs
// ****************
// Both inputs high would short the bridge, so every such cycle is counted
module pdg_gate_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic high_in,
  input wire logic low_in,
  output int overlap
);
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      overlap <= 0;
    end else if (high_in === 1'b1 && low_in === 1'b1) begin
      overlap <= overlap + 1;
    end
  end
endmodule : pdg_gate_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pdg_pkg::*;
  // ****************
  // Harness
  // ****************
  logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic ext_high_in = 0, ext_low_in = 0;
  logic [SW_W-1:0] sw = 0;
  logic [POT_W-1:0] pot = 0;
  logic [NBTN-1:0] btn_n = '1;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, hs, ls;
  int overlap, n_mismatch = 0, checks = 0;
  always #25 mclk = ~mclk;
  pdg_top #(.DEB_CYCLES(4)) pdg_top_i (.mclk(mclk), .arst_n(arst_n),
    .config_switch_bank(sw), .duty_potentiometer(pot), .buttons_n(btn_n),
    .ext_high_in(ext_high_in), .ext_low_in(ext_low_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_side_drive_in(hs), .low_side_drive_in(ls));
  pdg_gate_model pdg_gate_model_i (.mclk(mclk), .arst_n(arst_n),
    .high_in(hs), .low_in(ls), .overlap(overlap));
  // ****************
  // Tasks
  // ****************
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Wait is bounded; a missing pready counts as a fault
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_cyc
  task press(input int b);
    btn_n[b] <= 0;
    wait_cyc(14);
    btn_n[b] <= 1;
    wait_cyc(14);
  endtask : press
  task status(input logic [31:0] e, input logic [31:0] m);
    apb(0, REG_STATUS, 0);
    chk("status", e & m, r & m);
  endtask : status
  // ****************
  // Scenarios
  // ****************
  task t_cfg;
    logic [11:0] p, d;
    for (int f = 0; f < 8; f++) begin
      sw <= SW_W'({3'(7 - f), 3'(f)});
      p = 12'(CLK_HZ / (FSTEP_HZ * (f + 1)));
      d = 12'((7 - f) * DT_STEP_NS / CLK_NS);
      wait_cyc(4);
      apb(1, REG_CTRL, 32'h1);
      sw <= 6'h00;
      wait_cyc(4);
      status({4'h0, p, 2'b0, 6'({3'(7 - f), 3'(f)}), 8'h01}, 32'h0fff3f07);
      apb(0, REG_DUTY, 0);
      chk("dead", 32'(d), r >> 16);
      apb(1, REG_CTRL, 32'h1);
      wait_cyc(3);
      chk("stop", 0, {hs, ls});
    end
    $display("test cfg done");
  endtask : t_cfg
  task t_duty;
    sw <= 6'h07;
    pot <= 8'hff;
    wait_cyc(4);
    apb(1, REG_CTRL, 32'h1);
    wait_cyc(1100);
    apb(0, REG_DUTY, 0);
    chk("on max", 500 * 250 / 256, r & 32'hfff);
    pot <= 8'h00;
    wait_cyc(1100);
    apb(0, REG_DUTY, 0);
    chk("on min", 0, r & 32'hfff);
    apb(1, REG_CTRL, 32'h1);
    $display("test duty done");
  endtask : t_duty
  task t_dead;
    int p, d, o, nh, nl;
    p = CLK_HZ / (FSTEP_HZ * 8);
    d = 3 * DT_STEP_NS / CLK_NS;
    o = p * 64 / 256;
    nh = 0;
    nl = 0;
    sw <= 6'h1f;
    pot <= 8'h40;
    wait_cyc(4);
    apb(1, REG_CTRL, 32'h1);
    wait_cyc(600);
    repeat (p) begin
      @(posedge mclk);
      nh += hs;
      nl += ls;
    end
    chk("hi width", o - d, nh);
    chk("lo width", p - o - d, nl);
    apb(1, REG_CTRL, 32'h1);
    pot <= 8'h00;
    $display("test dead done");
  endtask : t_dead
  task t_ext;
    sw <= SW_ALL_ON;
    wait_cyc(4);
    apb(1, REG_CTRL, 32'h1);
    status(32'h5, 32'h7);
    ext_high_in <= 1;
    wait_cyc(5);
    chk("ext hi", 2'b10, {hs, ls});
    ext_low_in <= 1;
    wait_cyc(5);
    chk("ext both", 2'b00, {hs, ls});
    ext_high_in <= 0;
    wait_cyc(5);
    chk("ext lo", 2'b01, {hs, ls});
    apb(1, REG_CTRL, 32'h1);
    ext_low_in <= 0;
    $display("test ext done");
  endtask : t_ext
  task t_ctrl;
    sw <= 6'h00;
    press(BTN_START);
    status(32'h1, 32'h3);
    press(BTN_START);
    status(32'h0, 32'h3);
    apb(1, REG_CTRL, 32'h2);
    apb(1, REG_CTRL, 32'h1);
    status(32'h2, 32'h3);
    press(BTN_SLEEP);
    status(32'h0, 32'h3);
    press(BTN_START);
    press(BTN_RESET);
    status(32'h0, 32'h3);
    chk("overlap", 0, 32'(overlap));
    $display("test ctrl done");
  endtask : t_ctrl
  // ****************
  // Sequence
  // ****************
  initial begin
    wait_cyc(2);
    arst_n <= 1;
    chk("rst out", 0, {hs, ls});
    status(32'h0, 32'hffffffff);
    t_cfg;
    t_duty;
    t_dead;
    t_ext;
    t_ctrl;
    end_sim;
  end
  initial begin
    #2000000;
    n_mismatch++;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
